// file: rtl/dlqt_top.sv
// dac power-up sequencer, temperature tables and shared loss-of-signal quick trip
`default_nettype none
module dlqt_top #(
  parameter int INIT_CYCLES = dlqt_pkg::INIT_CYCLES
) (
  input  wire logic                         clock_i,
  input  wire logic                         srst_i,
  input  wire logic                         scl_i,
  input  wire logic                         sda_i,
  input  wire logic                         nv_write_pend_i,
  input  wire logic                         temp_conv_done_i,
  input  wire logic [dlqt_pkg::TBL_AW-1:0]  temp_index_i,
  input  wire logic                         vcc_conv_done_i,
  input  wire logic [dlqt_pkg::VCC_W-1:0]   vcc_result_i,
  input  wire logic [dlqt_pkg::VCC_W-1:0]   supply_low_alarm_level_i,
  input  wire logic                         supply_low_alarm_enable_i,
  input  wire logic [dlqt_pkg::DAC_W-1:0]   dac_init_one_i,
  input  wire logic [dlqt_pkg::DAC_W-1:0]   dac_init_two_i,
  input  wire logic                         tbl_wr_i,
  input  wire logic                         tbl_sel_i,
  input  wire logic [dlqt_pkg::TBL_AW-1:0]  tbl_addr_i,
  input  wire logic [dlqt_pkg::DAC_W-1:0]   tbl_data_i,
  input  wire logic [dlqt_pkg::QT_W-1:0]    rx_power_input_one_i,
  input  wire logic [dlqt_pkg::QT_W-1:0]    rx_power_input_two_i,
  input  wire logic [dlqt_pkg::QT_W-1:0]    low_power_trip_level_one_i,
  input  wire logic [dlqt_pkg::QT_W-1:0]    low_power_trip_level_two_i,
  input  wire logic [dlqt_pkg::QT_W-1:0]    low_power_warn_level_one_i,
  input  wire logic [dlqt_pkg::QT_W-1:0]    low_power_warn_level_two_i,
  input  wire logic [1:0]                   los_enable_i,
  output logic      [1:0]                   dac_ds_o,
  output logic      [1:0]                   dac_oe_o,
  output logic      [dlqt_pkg::DAC_W-1:0]   dac_code_one_o,
  output logic      [dlqt_pkg::DAC_W-1:0]   dac_code_two_o,
  output logic      [1:0]                   los_alarm_o,
  output logic      [1:0]                   los_warn_o,
  output logic                              qt_sel_o,
  output logic                              rx_signal_lost_output_o,
  output logic                              fault_hold_o,
  output logic                              nv_write_start_o
);
  typedef struct packed {
    dlqt_pkg::dlqt_state_t                 state;
    logic [dlqt_pkg::INIT_W-1:0]           init_cnt;
    logic [dlqt_pkg::SLOT_W-1:0]           slot_cnt;
    logic                                  sel;
    logic [dlqt_pkg::TBL_AW-1:0]           idx;
    logic                                  load;
    logic [1:0][dlqt_pkg::DAC_W-1:0]       code;
    logic [1:0][dlqt_pkg::DAC_W-1:0]       acc;
    logic [1:0]                            ds;
    logic [1:0]                            oe;
    logic                                  ds_en;
    logic [1:0]                            alarm;
    logic [1:0]                            warn;
    logic                                  los_out;
    logic                                  fault;
    logic                                  sda_d;
    logic                                  wr_pend;
    logic                                  wr_start;
  } dlqt_reg_t;

  dlqt_reg_t r;
  dlqt_reg_t next_r;

  logic [dlqt_pkg::DAC_W-1:0]  tbl_mem [2][dlqt_pkg::TBL_DEPTH];
  logic [1:0][dlqt_pkg::DAC_W-1:0] tbl_rd;
  logic [1:0]                  pin_s;
  logic                        scl_s;
  logic                        sda_s;
  logic                        stop_seen;
  logic                        slot_wrap;
  logic                        vcc_ok;
  logic [dlqt_pkg::QT_W-1:0]   qt_in;
  logic [dlqt_pkg::QT_W-1:0]   qt_trip;
  logic [dlqt_pkg::QT_W-1:0]   qt_warn;
  logic [dlqt_pkg::TBL_AW-1:0] temp_idx;

  // serial pins cross in from the bus; stop detect only looks at the second flop
  dlqt_sync2 #(
    .W (2)
  ) u_pin_sync (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .async_i ({scl_i, sda_i}),
    .sync_o  (pin_s)
  );
  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];

  // 125 mhz oversamples a 400 khz or slower bus many times over
  assign stop_seen = scl_s && sda_s && !r.sda_d;

  // table storage, one array per dac
  always_ff @(posedge clock_i) begin
    if (tbl_wr_i && (tbl_addr_i <= dlqt_pkg::TBL_LAST)) begin
      tbl_mem[tbl_sel_i][tbl_addr_i] <= tbl_data_i;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_rd
      assign tbl_rd[g] = tbl_mem[g][r.idx];
    end
  endgenerate

  // indices past the table end clamp to the last entry
  assign temp_idx  = (temp_index_i > dlqt_pkg::TBL_LAST) ? dlqt_pkg::TBL_LAST : temp_index_i;
  assign vcc_ok    = vcc_conv_done_i && (vcc_result_i > supply_low_alarm_level_i);
  assign slot_wrap = (r.slot_cnt == dlqt_pkg::SLOT_W'(dlqt_pkg::SLOT_CYCLES - 1));
  assign qt_in     = r.sel ? rx_power_input_two_i : rx_power_input_one_i;
  assign qt_trip   = r.sel ? low_power_trip_level_two_i : low_power_trip_level_one_i;
  assign qt_warn   = r.sel ? low_power_warn_level_two_i : low_power_warn_level_one_i;

  always_comb begin
    next_r = r;
    next_r.load = 1'h0;
    next_r.ds_en = !r.ds_en;
    next_r.sda_d = sda_s;
    // power-up sequence
    case (r.state)
      dlqt_pkg::ST_HIZ: begin
        next_r.init_cnt = r.init_cnt + 1'h1;
        if (r.init_cnt == dlqt_pkg::INIT_W'(INIT_CYCLES - 1)) begin
          next_r.oe    = 2'h3;
          next_r.code  = {dac_init_two_i, dac_init_one_i};
          next_r.state = dlqt_pkg::ST_WAIT_TEMP;
        end
      end
      dlqt_pkg::ST_WAIT_TEMP: begin
        if (temp_conv_done_i) begin
          next_r.idx = temp_idx;
          // a supply check, when armed, must follow the temperature result
          if (supply_low_alarm_enable_i) begin
            next_r.state = dlqt_pkg::ST_WAIT_VCC;
          end else begin
            next_r.state = dlqt_pkg::ST_TABLE;
            next_r.load  = 1'h1;
          end
        end
      end
      dlqt_pkg::ST_WAIT_VCC: begin
        if (temp_conv_done_i) begin
          next_r.idx = temp_idx;
        end
        if (vcc_ok) begin
          next_r.state = dlqt_pkg::ST_TABLE;
          next_r.load  = 1'h1;
        end
      end
      dlqt_pkg::ST_TABLE: begin
        if (temp_conv_done_i) begin
          next_r.idx  = temp_idx;
          next_r.load = 1'h1;
        end
      end
      default: begin
        next_r.state = dlqt_pkg::ST_HIZ;
      end
    endcase
    if (r.load) begin
      next_r.code  = tbl_rd;
      next_r.fault = 1'h0;
    end
    // delta-sigma modulators at half the clock rate
    for (int i = 0; i < 2; i++) begin
      if (r.ds_en) begin
        {next_r.ds[i], next_r.acc[i]} = {1'h0, r.acc[i]} + {1'h0, r.code[i]};
      end
      if (!r.oe[i]) begin
        next_r.ds[i] = 1'h0;
      end
    end
    // quick-trip slots alternate between the two receivers
    next_r.slot_cnt = slot_wrap ? '0 : r.slot_cnt + 1'h1;
    if (slot_wrap) begin
      next_r.sel = !r.sel;
      // flags only move on a sample of their own channel, so they hold in between
      next_r.alarm[r.sel] = (qt_in < qt_trip);
      next_r.warn[r.sel]  = (qt_in < qt_warn);
    end
    next_r.los_out = |(next_r.alarm & los_enable_i);
    // pending write held until the stop; a late pend in the stop cycle still counts
    next_r.wr_start = stop_seen && (r.wr_pend || nv_write_pend_i);
    next_r.wr_pend  = (r.wr_pend || nv_write_pend_i) && !stop_seen;
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      r       <= '0;
      r.code  <= {dlqt_pkg::DAC_RST_CODE, dlqt_pkg::DAC_RST_CODE};
      r.fault <= dlqt_pkg::FAULT_RST;
      r.sda_d <= 1'h1;
    end else begin
      r <= next_r;
    end
  end

  assign dac_ds_o                = r.ds;
  assign dac_oe_o                = r.oe;
  assign dac_code_one_o          = r.code[0];
  assign dac_code_two_o          = r.code[1];
  assign los_alarm_o             = r.alarm;
  assign los_warn_o              = r.warn;
  assign qt_sel_o                = r.sel;
  assign rx_signal_lost_output_o = r.los_out;
  assign fault_hold_o            = r.fault;
  assign nv_write_start_o        = r.wr_start;

  // checks
  logic [dlqt_pkg::INIT_W:0] since_rst;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      since_rst <= '0;
    end else if (since_rst <= (dlqt_pkg::INIT_W + 1)'(INIT_CYCLES)) begin
      since_rst <= since_rst + 1'h1;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  AST_HIZ_HOLD: assert property ((since_rst < (dlqt_pkg::INIT_W + 1)'(INIT_CYCLES)) |->
    (dac_oe_o == 2'h0 && dac_ds_o == 2'h0))
    else $error("dac left high impedance before the enable delay");
  AST_OE_TIME: assert property ((since_rst == (dlqt_pkg::INIT_W + 1)'(INIT_CYCLES)) |->
    (dac_oe_o == 2'h3))
    else $error("dac not enabled at the end of the enable delay");
  AST_INIT_CODE: assert property ($rose(dac_oe_o[0]) |->
    (dac_code_one_o == $past(dac_init_one_i) && dac_code_two_o == $past(dac_init_two_i)))
    else $error("dac did not start from its initial code");
  AST_NO_EARLY_TABLE: assert property (
    (r.state == dlqt_pkg::ST_WAIT_VCC && !vcc_ok) |=>
    (r.state == dlqt_pkg::ST_WAIT_VCC && !r.load))
    else $error("table codes enabled without a good supply reading");
  AST_TABLE_LOAD: assert property (r.load |=>
    (dac_code_one_o == $past(tbl_rd[0]) && dac_code_two_o == $past(tbl_rd[1])))
    else $error("dac code does not match its table entry");
  AST_ALTERNATE: assert property (slot_wrap |=> (qt_sel_o != $past(qt_sel_o)) ##1
    $stable(qt_sel_o)[*2])
    else $error("comparator select did not alternate once per slot");
  AST_SLOT_LEN: assert property (slot_wrap |=> (r.slot_cnt == '0) ##1 !slot_wrap)
    else $error("quick-trip slot length wrong");
  AST_ALARM_SET: assert property ((slot_wrap && !qt_sel_o) |=>
    (los_alarm_o[0] ==
      ($past(rx_power_input_one_i) < $past(low_power_trip_level_one_i))))
    else $error("receiver one alarm does not follow its sample");
  AST_ALARM_HOLD: assert property (!(slot_wrap && !qt_sel_o) |=> $stable(los_alarm_o[0]))
    else $error("receiver one alarm moved outside its own sample");
  AST_LOS_OUT: assert property (!$past(srst_i) |->
    (rx_signal_lost_output_o == |(los_alarm_o & $past(los_enable_i))))
    else $error("loss-of-signal output does not follow enabled alarms");
  AST_FAULT_HOLD: assert property ((fault_hold_o && !r.load) |=> fault_hold_o)
    else $error("fault hold released before table recall");
  AST_NV_STOP: assert property (nv_write_start_o |-> $past(stop_seen))
    else $error("nonvolatile write started without a stop");

  COV_ENABLE: cover property ($rose(dac_oe_o[0]));
  COV_FAULT_REL: cover property ($fell(fault_hold_o));
  COV_LOS: cover property ($rose(rx_signal_lost_output_o));
  COV_NV: cover property (nv_write_start_o);
endmodule : dlqt_top
`default_nettype wire

// file: include/dlqt_pkg.sv
// constants and types for the dac power-up sequencer and loss-of-signal quick trip
`default_nettype none
package dlqt_pkg;
  // clock
  localparam int CLK_MHZ        = 125;
  // output-enable delay after power-on, in ms, and its cycle count
  localparam int INIT_TIME_MS   = 20;
  localparam int INIT_CYCLES    = INIT_TIME_MS * CLK_MHZ * 1000;
  localparam int INIT_W         = 22;
  // one quick-trip sample slot, in us, rounded to the nearest cycle (typical figure)
  localparam real SLOT_TIME_US  = 12.8;
  localparam int SLOT_CYCLES    = int'(SLOT_TIME_US * CLK_MHZ);
  localparam int SLOT_W         = 11;
  // serial interface top rate, kHz; stop detect oversamples it by far
  localparam int SCL_MAX_KHZ    = 400;
  // widths and table shape
  localparam int DAC_W          = 10;
  localparam int QT_W           = 8;
  localparam int VCC_W          = 16;
  localparam int TBL_AW         = 7;
  localparam int TBL_DEPTH      = 72;
  localparam logic [TBL_AW-1:0] TBL_LAST = 7'h47;
  // reset values
  localparam logic [DAC_W-1:0] DAC_RST_CODE = 10'h000;
  localparam logic             FAULT_RST    = 1'h1;

  typedef enum logic [1:0] {
    ST_HIZ,
    ST_WAIT_TEMP,
    ST_WAIT_VCC,
    ST_TABLE
  } dlqt_state_t;
endpackage : dlqt_pkg
`default_nettype wire

// file: rtl/dlqt_sync2.sv
// two-flop synchroniser for pin inputs
`default_nettype none
module dlqt_sync2 #(
  parameter int W = 2
) (
  input  wire logic         clock_i,
  input  wire logic         srst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dlqt_sync_t;

  dlqt_sync_t r;
  dlqt_sync_t next_r;

  // first stage feeds only the second stage
  always_comb begin
    next_r.s1 = async_i;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      // pins idle high: resetting to ones keeps a false stop edge out after reset
      r <= '1;
    end else begin
      r <= next_r;
    end
  end

  assign sync_o = r.s2;
endmodule : dlqt_sync2
`default_nettype wire

// file: verif/dlqt_host_model.sv
// serial host model: drives the clock and data pins, ends transfers with a stop
`default_nettype none
module dlqt_host_model (
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // fast-mode timing, low 1.6 us and stop setup 0.6 us
  task automatic stop();
    scl_o = 1'b0;
    #1300;
    sda_o = 1'b0;
    #300;
    scl_o = 1'b1;
    #600;
    sda_o = 1'b1; // data rises with clock high: the stop
    #1300;
  endtask : stop
endmodule : dlqt_host_model
`default_nettype wire

// file: verif/dlqt_top_tb.sv
// testbench for the dac power-up sequencer and quick trip
`default_nettype none
module dlqt_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int INIT = 50;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic scl, sda, pend = 1'b0, tdone = 1'b0, vdone = 1'b0, slen = 1'b0, wr = 1'b0, sel = 1'b0;
  logic [6:0] tidx = 7'h00, addr = 7'h00;
  logic [15:0] vres = 16'h0000;
  logic [9:0] wdata = 10'h000;
  logic [7:0] rx1 = 8'h20, rx2 = 8'h50, trip1 = 8'h40, trip2 = 8'h40;
  logic [1:0] los_en = 2'h3;
  logic [1:0] ds, oe, alarm, warn;
  logic [9:0] code1, code2;
  logic qsel, lost, fault, nvst;
  int n_errors = 0, n_compared = 0, cyc = 0, n_start = 0;
  always #4 clock_i = ~clock_i;
  always @(posedge clock_i) cyc <= srst_i ? 0 : cyc + 1;
  always @(negedge clock_i) if (nvst === 1'b1) n_start++;
  dlqt_host_model host (.scl_o(scl), .sda_o(sda));
  dlqt_top #(.INIT_CYCLES(INIT)) dut (
    .clock_i(clock_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda),
    .nv_write_pend_i(pend), .temp_conv_done_i(tdone), .temp_index_i(tidx),
    .vcc_conv_done_i(vdone), .vcc_result_i(vres), .supply_low_alarm_level_i(16'h8000),
    .supply_low_alarm_enable_i(slen), .dac_init_one_i(10'h123), .dac_init_two_i(10'h234),
    .tbl_wr_i(wr), .tbl_sel_i(sel), .tbl_addr_i(addr), .tbl_data_i(wdata),
    .rx_power_input_one_i(rx1), .rx_power_input_two_i(rx2),
    .low_power_trip_level_one_i(trip1), .low_power_trip_level_two_i(trip2),
    .low_power_warn_level_one_i(8'h60), .low_power_warn_level_two_i(8'h60),
    .los_enable_i(los_en), .dac_ds_o(ds), .dac_oe_o(oe), .dac_code_one_o(code1),
    .dac_code_two_o(code2), .los_alarm_o(alarm), .los_warn_o(warn), .qt_sel_o(qsel),
    .rx_signal_lost_output_o(lost), .fault_hold_o(fault), .nv_write_start_o(nvst));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  task automatic wait_cyc(input int n);
    while (cyc < n) @(negedge clock_i);
  endtask : wait_cyc
  task automatic tbl_write(input logic s, input logic [6:0] a, input logic [9:0] d);
    {wr, sel, addr, wdata} = {1'b1, s, a, d};
    @(negedge clock_i);
    wr = 1'b0;
    @(negedge clock_i);
  endtask : tbl_write
  task automatic temp_pulse(input logic [6:0] i);
    {tdone, tidx} = {1'b1, i};
    @(negedge clock_i);
    tdone = 1'b0;
    repeat (2) @(negedge clock_i);
  endtask : temp_pulse
  task automatic vcc_pulse(input logic [15:0] v);
    {vdone, vres} = {1'b1, v};
    @(negedge clock_i);
    vdone = 1'b0;
    repeat (2) @(negedge clock_i);
  endtask : vcc_pulse
  task automatic codes(input logic [9:0] e1, input logic [9:0] e2, input logic f);
    check("code one", 16'(code1), 16'(e1));
    check("code two", 16'(code2), 16'(e2));
    check("fault hold", 16'(fault), 16'(f));
  endtask : codes
  task automatic t_powerup();
    wait_cyc(INIT - 1);
    check("oe before delay", 16'(oe), 16'h0000);
    check("ds before delay", 16'(ds), 16'h0000);
    wait_cyc(INIT);
    check("oe after delay", 16'(oe), 16'h0003);
    codes(10'h123, 10'h234, 1'b1);
  endtask : t_powerup
  task automatic t_gating();
    tbl_write(1'b0, 7'h05, 10'h155);
    tbl_write(1'b1, 7'h05, 10'h2aa);
    tbl_write(1'b0, 7'h47, 10'h0f0);
    tbl_write(1'b1, 7'h47, 10'h30f);
    slen = 1'b1;
    temp_pulse(7'h05);
    codes(10'h123, 10'h234, 1'b1);
    vcc_pulse(16'h8000); // equal is not above the level
    codes(10'h123, 10'h234, 1'b1);
    vcc_pulse(16'h8001);
    codes(10'h155, 10'h2aa, 1'b0);
    temp_pulse(7'h64); // index past the table clamps to the last entry
    codes(10'h0f0, 10'h30f, 1'b0);
  endtask : t_gating
  task automatic t_nvwrite();
    n_start = 0;
    pend = 1'b1;
    @(negedge clock_i);
    pend = 1'b0;
    repeat (20) @(negedge clock_i);
    check("start before stop", 16'(n_start), 16'h0000);
    host.stop();
    repeat (10) @(negedge clock_i);
    check("start after stop", 16'(n_start), 16'h0001);
    host.stop(); // nothing pending, no start
    repeat (10) @(negedge clock_i);
    check("start without pend", 16'(n_start), 16'h0001);
  endtask : t_nvwrite
  task automatic t_quicktrip();
    wait_cyc(1599);
    check("alarm before slot", 16'(alarm), 16'h0000);
    check("sel first", 16'(qsel), 16'h0000);
    wait_cyc(1600);
    check("alarm ch one", 16'(alarm), 16'h0001);
    check("warn ch one", 16'(warn), 16'h0001);
    check("sel toggles", 16'(qsel), 16'h0001);
    check("lost on", 16'(lost), 16'h0001);
    wait_cyc(3200);
    check("warn ch two", 16'(warn), 16'h0003);
    check("alarm ch two", 16'(alarm), 16'h0001);
    check("sel back", 16'(qsel), 16'h0000);
    wait_cyc(3300);
    {rx1, rx2, los_en} = {8'h70, 8'h30, 2'h2};
    wait_cyc(4799);
    check("alarm holds", 16'(alarm), 16'h0001);
    wait_cyc(4800);
    check("alarm clears", 16'(alarm), 16'h0000);
    check("warn ch one clears", 16'(warn), 16'h0002);
    check("lost off", 16'(lost), 16'h0000);
    wait_cyc(6400);
    check("alarm two", 16'(alarm), 16'h0002);
    check("lost by two", 16'(lost), 16'h0001);
  endtask : t_quicktrip
  // one value per modulator step: each bit stands two cycles, so sample every second cycle
  task automatic t_dsout();
    int n0 = 0;
    int n1 = 0;
    repeat (1024) begin
      repeat (2) @(negedge clock_i);
      n0 += int'(ds[0]);
      n1 += int'(ds[1]);
    end
    check("ds one ones per 1024", 16'(n0), 16'h00f0);
    check("ds two ones per 1024", 16'(n1), 16'h030f);
  endtask : t_dsout
  // second reset mid-run, then table mode without the supply alarm armed
  task automatic t_reset();
    srst_i = 1'b1;
    repeat (8) @(negedge clock_i);
    srst_i = 1'b0;
    @(negedge clock_i);
    check("alarm after reset", 16'(alarm), 16'h0000);
    check("lost after reset", 16'(lost), 16'h0000);
    check("oe after reset", 16'(oe), 16'h0000);
    check("fault after reset", 16'(fault), 16'h0001);
    slen = 1'b0;
    wait_cyc(INIT);
    codes(10'h123, 10'h234, 1'b1);
    temp_pulse(7'h05);
    codes(10'h155, 10'h2aa, 1'b0);
  endtask : t_reset
  initial begin
    repeat (8) @(negedge clock_i);
    srst_i = 1'b0;
    t_powerup();
    t_gating();
    t_nvwrite();
    t_quicktrip(); // slow, the slot is a fixed 1600 cycles
    t_dsout();
    t_reset();
    report_and_stop();
  end
  initial begin
    #(8 * 20000);
    n_errors++;
    report_and_stop();
  end
endmodule : dlqt_top_tb
`default_nettype wire
